// ===== bench/micin_host.sv
`timescale 1ns/1ps
`default_nettype none
module micin_host
    import micin_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // write strobe into the register bank
    output var micin_wr_t wr_req
);
    logic [2:0] pos_mix;

    initial
    begin
        wr_req = '0;
        pos_mix = MICIN_PATH_OFF;
    end

    // one write per call, raised and dropped on falling edges so it never meets the sampling edge
    task automatic write(input logic [6:0] addr, input logic [8:0] data, output logic [8:0] sent);
        sent = data;
        // pin fed straight to the mixer: preamp plus input must sit on mid rail
        if (addr == MICIN_ADDR_ROUTE && pos_mix != MICIN_PATH_OFF)
            sent[MICIN_BIT_POS_PRE] = 1'b0;
        if (addr == MICIN_ADDR_MIXER)
            pos_mix = data[6:4];
        @(negedge clk_sys);
        wr_req <= '{wr: 1'b1, addr: addr, data: sent};
        @(negedge clk_sys);
        wr_req <= '0;
    endtask
endmodule
`default_nettype wire

// ===== bench/test_mic_input_path_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_mic_input_path_control;
    import micin_pkg::*;
    localparam logic [6:0] ADDRS [6] = '{7'h01, 7'h02, 7'h20, 7'h2C, 7'h2D, 7'h2F};
    // only documented fields are compared, other bits of shared registers are not ours
    localparam logic [8:0] MASKS [6] = '{9'h050, 9'h010, 9'h100, 9'h10F, 9'h0FF, 9'h177};
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic zero_cross_in = 1'b0;
    logic [6:0] rd_addr = 7'h00;
    logic [5:0] loop_gain_code = 6'h00;
    micin_wr_t wr_req;
    logic [8:0] rd_data;
    micin_ctrl_t ctrl;
    logic mic_supply_pin_o;
    logic mic_supply_pin_oe;
    int fails = 0;
    int checked = 0;
    logic [8:0] regs [6] = '{MICIN_RST_PWR_ONE, MICIN_RST_PWR_TWO, MICIN_RST_ALC_ONE, MICIN_RST_ROUTE,
        MICIN_RST_GAIN, MICIN_RST_MIXER};
    logic [5:0] applied = MICIN_GAIN_UNITY;

    micin_host u_micin_host (.clk_sys(clk_sys), .wr_req(wr_req));
    micin_ctrl u_micin_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .wr_req(wr_req), .rd_addr(rd_addr),
        .rd_data(rd_data), .zero_cross_in(zero_cross_in), .loop_gain_code(loop_gain_code), .ctrl(ctrl),
        .mic_supply_pin_o(mic_supply_pin_o), .mic_supply_pin_oe(mic_supply_pin_oe));

    // 40 MHz
    always #12.5 clk_sys = ~clk_sys;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic results();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // expected analog controls from the model registers
    function automatic micin_ctrl_t exp_ctrl();
        micin_ctrl_t c;
        c.preamp_gain_code = regs[2][8] ? loop_gain_code : applied;
        c.preamp_mute = regs[4][6];
        c.preamp_to_mixer_plus20 = regs[5][8];
        c.third_input_to_mixer_gain = regs[5][2:0];
        c.pos_mic_to_mixer_gain = regs[5][6:4];
        c.third_input_amp_en = regs[0][6];
        c.resistor_bypass_switch = regs[3][3];
        c.mixer_stage_en = regs[1][4];
        c.mic_supply_en = regs[0][4];
        c.mic_supply_level_sel = regs[3][8];
        c.pos_mic_to_preamp = regs[3][0];
        return c;
    endfunction

    // write through the host and mirror what was really sent; verify, not this task, lets the outputs settle
    task automatic wr(input int idx, input logic [8:0] data);
        logic [8:0] sent;
        u_micin_host.write(ADDRS[idx], data, sent);
        regs[idx] = sent;
        if (idx == 4 && !sent[MICIN_BIT_ZC])
            applied = sent[5:0];
    endtask

    task automatic verify(input string name);
        logic [8:0] e;
        repeat (4) @(posedge clk_sys);
        for (int i = 0; i < 6; i++)
        begin
            @(negedge clk_sys);
            rd_addr = ADDRS[i];
            #1;
            e = regs[i] & MASKS[i];
            if (i == 4 && regs[2][8])
                e[5:0] = loop_gain_code;
            check(rd_data & MASKS[i], e, "readback");
        end
        check(ctrl, exp_ctrl(), "controls");
        check(mic_supply_pin_oe, regs[0][4], "supply drive");
        check(mic_supply_pin_o, regs[0][4], "supply on");
        $display("test %s done", name);
    endtask

    initial
    begin
        #200us;
        fails++;
        results();
    end

    initial
    begin
        logic [5:0] code;
        logic [8:0] junk;
        void'($urandom(2));
        repeat (8) @(negedge clk_sys);
        rst_n = 1'b1;
        check(ctrl.preamp_gain_code, 6'h10, "unity gain");
        check(ctrl.preamp_mute, 1'b1, "mute at reset");
        verify("reset");
        // random traffic, some back to back, zero cross off so gains land at once
        for (int n = 0; n < 40; n++)
        begin
            loop_gain_code = 6'($urandom);
            wr(n % 6, 9'($urandom) & ~9'h080);
            wr($urandom_range(0, 5), 9'($urandom) & ~9'h080);
            verify("random");
        end
        // unmapped place: ignored and reads zero
        wr(0, 9'h050);
        u_micin_host.write(7'h03, 9'h1FF, junk);
        verify("unmapped");
        rd_addr = 7'h03;
        #1;
        check(rd_data, 9'h000, "unmapped read");
        // manual code written while the loop owns the gain
        wr(2, 9'h100);
        wr(4, 9'h03F);
        loop_gain_code = 6'h05;
        verify("loop owns gain");
        wr(2, 9'h000);
        verify("manual again");
        // deferred gain, both edges of the crossing input
        for (int k = 0; k < 2; k++)
        begin
            code = 6'($urandom) ^ applied;
            wr(4, {3'b010, code});
            repeat (8) @(posedge clk_sys);
            verify("held for crossing");
            @(negedge clk_sys);
            zero_cross_in = ~zero_cross_in;
            repeat (6) @(posedge clk_sys);
            applied = code;
            verify("crossing applied");
        end
        results();
    end
endmodule
`default_nettype wire

// ===== src/micin_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module micin_ctrl
    import micin_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register write port from the control interface
    input wire micin_wr_t wr_req,
    input wire logic [6:0] rd_addr,
    output logic [8:0] rd_data,
    // analog path status
    input wire logic zero_cross_in,
    input wire logic [5:0] loop_gain_code,
    // analog path controls
    output micin_ctrl_t ctrl,
    output logic mic_supply_pin_o,
    output logic mic_supply_pin_oe
);
    typedef struct packed {
        logic [8:0] pwr_one;
        logic [8:0] pwr_two;
        logic [8:0] alc_one;
        logic [8:0] route;
        logic [8:0] gain;
        logic [8:0] mixer;
        logic [5:0] applied_gain;
        logic pending;
        micin_ctrl_t outs;
    } micin_state_t;

    micin_state_t st_ff;
    micin_state_t nxt_st;
    logic zc_sync;
    logic zc_prev_ff;
    logic zc_edge;

    // zero crossing comes from the analog side, so synchronise it
    micin_sync u_zc_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .din(zero_cross_in),
        .dout(zc_sync)
    );

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            zc_prev_ff <= 1'b0;
        else
            zc_prev_ff <= zc_sync;
    end

    // either edge of the indication marks a crossing
    assign zc_edge = zc_sync ^ zc_prev_ff;

    // next-state logic: register writes, gain shadowing, output decode
    always_comb
    begin
        nxt_st = st_ff;
        if (wr_req.wr)
        begin
            if (wr_req.addr == MICIN_ADDR_PWR_ONE)
                nxt_st.pwr_one = wr_req.data;
            else if (wr_req.addr == MICIN_ADDR_PWR_TWO)
                nxt_st.pwr_two = wr_req.data;
            else if (wr_req.addr == MICIN_ADDR_ALC_ONE)
                nxt_st.alc_one = wr_req.data;
            else if (wr_req.addr == MICIN_ADDR_ROUTE)
                nxt_st.route = wr_req.data;
            else if (wr_req.addr == MICIN_ADDR_GAIN)
                nxt_st.gain = wr_req.data;
            else if (wr_req.addr == MICIN_ADDR_MIXER)
                nxt_st.mixer = wr_req.data;
        end
        if (!st_ff.gain[MICIN_BIT_ZC])
        begin
            nxt_st.applied_gain = st_ff.gain[5:0];
            nxt_st.pending = 1'b0;
        end
        else if (st_ff.pending && zc_edge)
        begin
            nxt_st.applied_gain = st_ff.gain[5:0];
            nxt_st.pending = 1'b0;
        end
        // a gain write with zero-cross armed waits in the shadow; it wins over any clear above
        if (wr_req.wr && wr_req.addr == MICIN_ADDR_GAIN)
            nxt_st.pending = wr_req.data[MICIN_BIT_ZC];
        // loop owns the gain; manual writes are then shadow only
        if (st_ff.alc_one[MICIN_BIT_AUTO_SEL])
            nxt_st.outs.preamp_gain_code = loop_gain_code;
        else
            nxt_st.outs.preamp_gain_code = st_ff.applied_gain;
        nxt_st.outs.preamp_mute = st_ff.gain[MICIN_BIT_MUTE];
        nxt_st.outs.preamp_to_mixer_plus20 = st_ff.mixer[MICIN_BIT_PLUS20];
        nxt_st.outs.third_input_to_mixer_gain = st_ff.mixer[2:0];
        nxt_st.outs.pos_mic_to_mixer_gain = st_ff.mixer[MICIN_POS_GAIN_LSB+:3];
        nxt_st.outs.third_input_amp_en = st_ff.pwr_one[MICIN_BIT_AMP_EN];
        nxt_st.outs.resistor_bypass_switch = st_ff.route[MICIN_BIT_MIX_SEL];
        nxt_st.outs.mixer_stage_en = st_ff.pwr_two[MICIN_BIT_MIXER_EN];
        nxt_st.outs.mic_supply_en = st_ff.pwr_one[MICIN_BIT_SUPPLY_EN];
        nxt_st.outs.mic_supply_level_sel = st_ff.route[MICIN_BIT_LEVEL_SEL];
        nxt_st.outs.pos_mic_to_preamp = st_ff.route[MICIN_BIT_POS_PRE];
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_ff.pwr_one <= MICIN_RST_PWR_ONE;
            st_ff.pwr_two <= MICIN_RST_PWR_TWO;
            st_ff.alc_one <= MICIN_RST_ALC_ONE;
            st_ff.route <= MICIN_RST_ROUTE;
            st_ff.gain <= MICIN_RST_GAIN;
            st_ff.mixer <= MICIN_RST_MIXER;
            st_ff.applied_gain <= MICIN_GAIN_UNITY;
            st_ff.pending <= 1'b0;
            st_ff.outs <= '{preamp_gain_code: MICIN_GAIN_UNITY, preamp_mute: 1'b1, default: '0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // readback; preamp gain reads the gain in use while the loop runs
    always_comb
    begin
        rd_data = 9'h000;
        if (rd_addr == MICIN_ADDR_PWR_ONE)
            rd_data = st_ff.pwr_one;
        else if (rd_addr == MICIN_ADDR_PWR_TWO)
            rd_data = st_ff.pwr_two;
        else if (rd_addr == MICIN_ADDR_ALC_ONE)
            rd_data = st_ff.alc_one;
        else if (rd_addr == MICIN_ADDR_ROUTE)
            rd_data = st_ff.route;
        else if (rd_addr == MICIN_ADDR_GAIN)
        begin
            if (st_ff.alc_one[MICIN_BIT_AUTO_SEL])
                rd_data = {st_ff.gain[8:6], st_ff.outs.preamp_gain_code};
            else
                rd_data = st_ff.gain;
        end
        else if (rd_addr == MICIN_ADDR_MIXER)
            rd_data = st_ff.mixer;
    end

    assign ctrl = st_ff.outs;
    // supply floats while disabled
    assign mic_supply_pin_o = st_ff.outs.mic_supply_en;
    assign mic_supply_pin_oe = st_ff.outs.mic_supply_en;

    // assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);


    // mute output copies the register bit one edge later
    mute_follows_reg_a: assert property (ctrl.preamp_mute == $past(st_ff.gain[MICIN_BIT_MUTE]))
        else $error("mute output not following register");

    // a write to the first power register reaches the amplifier enable
    amp_en_write_a: assert property (wr_req.wr && wr_req.addr == MICIN_ADDR_PWR_ONE
        |-> ##2 ctrl.third_input_amp_en == $past(wr_req.data[MICIN_BIT_AMP_EN], 2))
        else $error("third input enable not applied two cycles after write");

    // bypass switch follows the mix select
    bypass_sw_a: assert property (ctrl.resistor_bypass_switch == $past(st_ff.route[MICIN_BIT_MIX_SEL]))
        else $error("bypass switch wrong");

    // preamp boost select
    plus20_a: assert property (ctrl.preamp_to_mixer_plus20 == $past(st_ff.mixer[MICIN_BIT_PLUS20]))
        else $error("plus20 select wrong");

    // third input path gain, 000 is the cut path
    aux_gain_a: assert property (ctrl.third_input_to_mixer_gain == $past(st_ff.mixer[2:0]))
        else $error("third input gain wrong");

    // positive mic path gain, 000 is the cut path
    pos_gain_a: assert property (ctrl.pos_mic_to_mixer_gain == $past(st_ff.mixer[6:4]))
        else $error("positive mic gain wrong");

    // mixer stage power
    mixer_en_a: assert property (ctrl.mixer_stage_en == $past(st_ff.pwr_two[MICIN_BIT_MIXER_EN]))
        else $error("mixer enable wrong");

    // supply enable follows its register bit
    supply_en_a: assert property (ctrl.mic_supply_en == $past(st_ff.pwr_one[MICIN_BIT_SUPPLY_EN]))
        else $error("supply enable wrong");

    // supply pin floats while disabled
    supply_hiz_a: assert property (!ctrl.mic_supply_en |-> !mic_supply_pin_oe)
        else $error("supply driven while disabled");

    // supply ratio select
    level_sel_a: assert property (ctrl.mic_supply_level_sel == $past(st_ff.route[MICIN_BIT_LEVEL_SEL]))
        else $error("supply level wrong");

    // preamp plus input routing
    pos_pre_a: assert property (ctrl.pos_mic_to_preamp == $past(st_ff.route[MICIN_BIT_POS_PRE]))
        else $error("positive preamp routing wrong");

    // loop owns the gain output
    loop_gain_a: assert property (st_ff.alc_one[MICIN_BIT_AUTO_SEL]
        |=> ctrl.preamp_gain_code == $past(loop_gain_code))
        else $error("loop gain not used");

    // manual mode shows the applied shadow
    manual_gain_a: assert property (!st_ff.alc_one[MICIN_BIT_AUTO_SEL]
        |=> ctrl.preamp_gain_code == $past(st_ff.applied_gain))
        else $error("manual gain not used");

    // immediate mode: shadow tracks the register every edge
    immediate_gain_a: assert property (!st_ff.gain[MICIN_BIT_ZC]
        |=> st_ff.applied_gain == $past(st_ff.gain[5:0]))
        else $error("immediate gain not applied");

    // no crossing, no change
    zc_hold_a: assert property (st_ff.gain[MICIN_BIT_ZC] && !zc_edge && $past(st_ff.gain[MICIN_BIT_ZC])
        |=> $stable(st_ff.applied_gain))
        else $error("gain changed without crossing");

    // a crossing moves the held code into use
    zc_apply_a: assert property (st_ff.gain[MICIN_BIT_ZC] && st_ff.pending && zc_edge
        |=> st_ff.applied_gain == $past(st_ff.gain[5:0]))
        else $error("held gain not applied at crossing");

    // a deferred write always arms the shadow, even from immediate mode
    zc_arm_a: assert property (wr_req.wr && wr_req.addr == MICIN_ADDR_GAIN && wr_req.data[MICIN_BIT_ZC]
        |=> st_ff.pending)
        else $error("deferred write not pending");

    // immediate mode drops a stale pending flag
    zc_clear_a: assert property (!st_ff.gain[MICIN_BIT_ZC] && !(wr_req.wr && wr_req.addr == MICIN_ADDR_GAIN)
        |=> !st_ff.pending)
        else $error("pending left set in immediate mode");

    // gain register takes the write
    gain_write_a: assert property (wr_req.wr && wr_req.addr == MICIN_ADDR_GAIN
        |=> st_ff.gain == $past(wr_req.data))
        else $error("gain write lost");

    // routing register takes the write
    route_write_a: assert property (wr_req.wr && wr_req.addr == MICIN_ADDR_ROUTE
        |=> st_ff.route == $past(wr_req.data))
        else $error("routing write lost");

    // mixer register takes the write
    mixer_write_a: assert property (wr_req.wr && wr_req.addr == MICIN_ADDR_MIXER
        |=> st_ff.mixer == $past(wr_req.data))
        else $error("mixer write lost");

    // first power register takes the write
    pwr_one_write_a: assert property (wr_req.wr && wr_req.addr == MICIN_ADDR_PWR_ONE
        |=> st_ff.pwr_one == $past(wr_req.data))
        else $error("first power write lost");

    // second power register takes the write
    pwr_two_write_a: assert property (wr_req.wr && wr_req.addr == MICIN_ADDR_PWR_TWO
        |=> st_ff.pwr_two == $past(wr_req.data))
        else $error("second power write lost");

    // level loop register takes the write
    alc_write_a: assert property (wr_req.wr && wr_req.addr == MICIN_ADDR_ALC_ONE
        |=> st_ff.alc_one == $past(wr_req.data))
        else $error("level loop write lost");

    // a stray address must not disturb any enable
    stray_write_a: assert property (wr_req.wr && wr_req.addr != MICIN_ADDR_PWR_ONE && wr_req.addr != MICIN_ADDR_PWR_TWO
        && wr_req.addr != MICIN_ADDR_ALC_ONE && wr_req.addr != MICIN_ADDR_ROUTE && wr_req.addr != MICIN_ADDR_GAIN
        && wr_req.addr != MICIN_ADDR_MIXER |=> $stable(st_ff.pwr_one) && $stable(st_ff.pwr_two)
        && $stable(st_ff.alc_one) && $stable(st_ff.route) && $stable(st_ff.gain) && $stable(st_ff.mixer))
        else $error("stray write changed a register");

    // main scenarios
    // held code applied on a crossing
    cov_zc_apply: cover property (st_ff.pending && zc_edge);
    // loop in charge of gain
    cov_loop_on: cover property (st_ff.alc_one[MICIN_BIT_AUTO_SEL]);
    // preamp live
    cov_unmute: cover property (!ctrl.preamp_mute);
    // supply pin driven
    cov_supply_on: cover property (mic_supply_pin_oe);
    // boost selected
    cov_plus20: cover property (ctrl.preamp_to_mixer_plus20);
endmodule
`default_nettype wire

// ===== src/micin_pkg.sv
package micin_pkg;
    // register addresses (7-bit register index of the control port)
    localparam logic [6:0] MICIN_ADDR_PWR_ONE = 7'h01;
    localparam logic [6:0] MICIN_ADDR_PWR_TWO = 7'h02;
    localparam logic [6:0] MICIN_ADDR_ALC_ONE = 7'h20;
    localparam logic [6:0] MICIN_ADDR_ROUTE = 7'h2C;
    localparam logic [6:0] MICIN_ADDR_GAIN = 7'h2D;
    localparam logic [6:0] MICIN_ADDR_MIXER = 7'h2F;
    // field positions
    localparam int MICIN_BIT_AMP_EN = 6;
    localparam int MICIN_BIT_SUPPLY_EN = 4;
    localparam int MICIN_BIT_MIXER_EN = 4;
    localparam int MICIN_BIT_AUTO_SEL = 8;
    localparam int MICIN_BIT_LEVEL_SEL = 8;
    localparam int MICIN_BIT_MIX_SEL = 3;
    localparam int MICIN_BIT_POS_PRE = 0;
    localparam int MICIN_BIT_ZC = 7;
    localparam int MICIN_BIT_MUTE = 6;
    localparam int MICIN_BIT_PLUS20 = 8;
    localparam int MICIN_POS_GAIN_LSB = 4;
    // reset values
    localparam logic [8:0] MICIN_RST_PWR_ONE = 9'h000;
    localparam logic [8:0] MICIN_RST_PWR_TWO = 9'h000;
    localparam logic [8:0] MICIN_RST_ALC_ONE = 9'h000;
    localparam logic [8:0] MICIN_RST_ROUTE = 9'h002;
    localparam logic [8:0] MICIN_RST_GAIN = 9'h050;
    localparam logic [8:0] MICIN_RST_MIXER = 9'h000;
    localparam logic [5:0] MICIN_GAIN_UNITY = 6'h10;
    localparam logic [2:0] MICIN_PATH_OFF = 3'h0;

    // analog control outputs
    typedef struct packed {
        logic [5:0] preamp_gain_code;
        logic preamp_mute;
        logic preamp_to_mixer_plus20;
        logic [2:0] third_input_to_mixer_gain;
        logic [2:0] pos_mic_to_mixer_gain;
        logic third_input_amp_en;
        logic resistor_bypass_switch;
        logic mixer_stage_en;
        logic mic_supply_en;
        logic mic_supply_level_sel;
        logic pos_mic_to_preamp;
    } micin_ctrl_t;

    // register write strobe from the control port
    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [8:0] data;
    } micin_wr_t;
endpackage

// ===== src/micin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module micin_sync
    import micin_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // async level in, synchronised level out
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic meta;
        logic sync;
    } micin_sync_st_t;

    micin_sync_st_t st_ff;
    micin_sync_st_t nxt_st;

    // first stage feeds only the second
    always_comb
    begin
        nxt_st.meta = din;
        nxt_st.sync = st_ff.meta;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign dout = st_ff.sync;
endmodule
`default_nettype wire
